// >>> hdl/tbc_pkg.sv
package tbc_pkg;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int             TBC_CNT_W        = 16;
  localparam int             TBC_REP_W        = 8;
  localparam logic [15:0]    TBC_ARR_RESET    = 16'hFFFF;
  localparam logic [15:0]    TBC_PSC_RESET    = 16'h0000;
  localparam logic [7:0]     TBC_REP_RESET    = 8'h00;
  localparam logic [15:0]    TBC_CNT_RESET    = 16'h0000;

  // ------------------------------------------------------------------
  // field encodings
  // ------------------------------------------------------------------
  localparam logic [1:0]     TBC_CMS_EDGE     = 2'h0;
  localparam logic [1:0]     TBC_CMS_DOWNFLAG = 2'h1;
  localparam logic [1:0]     TBC_CMS_UPFLAG   = 2'h2;
  localparam logic [1:0]     TBC_CMS_BOTH     = 2'h3;
  localparam logic [2:0]     TBC_SMS_OFF      = 3'h0;

  typedef enum logic [1:0] {
    TBC_CLK_INTERNAL,
    TBC_CLK_PIN,
    TBC_CLK_EXTTRIG,
    TBC_CLK_INTTRIG
  } tbc_clk_sel_t;

  // control bits grouped as they would sit in control_register_one
  typedef struct packed {
    logic                    counterEnable;
    logic                    updateDisable;
    logic                    updateRequestSource;
    logic                    reloadPreloadEnable;
    logic                    direction;
    logic [1:0]              centerAlignSelect;
  } tbc_ctrl_t;

  // status toward the rest of the timer
  typedef struct packed {
    logic                    updateEvent;
    logic                    overflow;
    logic                    underflow;
    logic                    countingDown;
    logic                    compareFlagWindow;
  } tbc_stat_t;

endpackage : tbc_pkg

// >>> hdl/tbc_time_base.sv
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) up mode counts 0..reload, wraps, overflows
// (RULE_02) update only after repetition plus one overflows
// (RULE_03) force update gives update in every mode
// (RULE_04) update disable blocks update and shadow loads
// (RULE_05) request source hides flag on forced update
// (RULE_06) update reloads repetition, reload shadow, prescaler
// (RULE_07) down mode counts reload..0, reloads, underflows
// (RULE_08) down mode, disabled updates: restart active reload
// (RULE_09) down mode loads new shadow before counter
// (RULE_10) center mode: up to reload-1, down to 1
// (RULE_11) center select picks compare flag direction
// (RULE_12) center mode direction is hardware driven
// (RULE_13) center updates both ways; force restarts counters
// (RULE_14) center mode, disabled updates: keep counting
// (RULE_15) repetition decrements per over/underflow; update at zero
// (RULE_16) shadow transfers every repetition plus one flows
// (RULE_17) forced update immediate, reloads repetition counter
// (RULE_18) odd repetition: phase set by write timing
// (RULE_19) center mode limits repetition to 128 periods
// (RULE_20) counter tick source selectable among four
// (RULE_21) slave off: software bits only; internal clock (code: tick source still set by clkSelect in every slave mode)
// (RULE_22) reload shadow immediate or at update
// (RULE_23) prescaler divides 1..65536, new ratio at update
// (RULE_24) counting begins one cycle after enable
module tbc_time_base
  import tbc_pkg::*;
#(
  parameter int CNT_W = TBC_CNT_W,
  parameter int REP_W = TBC_REP_W
)(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // control
  input  wire tbc_pkg::tbc_ctrl_t   ctrl,
  input  wire logic [2:0]           slaveModeSelect,
  input  wire tbc_pkg::tbc_clk_sel_t clkSelect,
  input  wire logic                 forceUpdateBit,
  input  wire logic                 slaveForceUpdate,
  input  wire logic                 updateFlagClear,
  // preload values
  input  wire logic [CNT_W-1:0]     autoReloadValue,
  input  wire logic [CNT_W-1:0]     prescalerValue,
  input  wire logic [REP_W-1:0]     repetitionValue,
  // external tick sources
  input  wire logic                 pinClock,
  input  wire logic                 externalTriggerInput,
  input  wire logic                 internalTriggerInputs,
  // outputs
  output tbc_pkg::tbc_stat_t        stat,
  output logic                      updateFlag,
  output logic [CNT_W-1:0]          counterValue,
  output logic [CNT_W-1:0]          activeReload
);
  import tbc_pkg::*;

  // ------------------------------------------------------------------
  // tick source synchronisers and edge detect
  // ------------------------------------------------------------------
  logic [2:0] srcMeta;
  logic [2:0] srcSync;
  logic [2:0] srcPrev;
  logic       extTick;

  // rising edge of a synchronised tick source
  function automatic logic rise_of(input logic nowLevel, input logic lastLevel);
    rise_of = nowLevel & ~lastLevel;
  endfunction : rise_of

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      srcMeta <= 3'h0;
      srcSync <= 3'h0;
    end
    else
    begin
      srcMeta <= {internalTriggerInputs, externalTriggerInput, pinClock};
      srcSync <= srcMeta;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      srcPrev <= 3'h0;
    else
      srcPrev <= srcSync;
  end

  always_comb
  begin
    case (clkSelect) // [RULE_20]
      TBC_CLK_PIN:     extTick = rise_of(srcSync[0], srcPrev[0]);
      TBC_CLK_EXTTRIG: extTick = rise_of(srcSync[1], srcPrev[1]);
      TBC_CLK_INTTRIG: extTick = rise_of(srcSync[2], srcPrev[2]);
      default:         extTick = 1'b1; // [RULE_21]
    endcase
  end

  // ------------------------------------------------------------------
  // enable delay and prescaler
  // ------------------------------------------------------------------
  logic             running;
  logic [CNT_W-1:0] pscCount;
  logic [CNT_W-1:0] pscActive;
  logic             counterTick;
  logic             forceNow;
  logic             updateEvent;

  // slave-driven force only honoured when slave mode is on
  assign forceNow = forceUpdateBit | (slaveForceUpdate & (slaveModeSelect != TBC_SMS_OFF)); // [RULE_21]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      running <= 1'b0;
    else
      running <= ctrl.counterEnable; // [RULE_24]
  end

  assign counterTick = running & extTick & (pscCount == pscActive);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pscCount <= TBC_PSC_RESET;
    else if (forceNow)
      pscCount <= '0; // [RULE_13]
    else if (running & extTick)
      pscCount <= (pscCount == pscActive) ? '0 : pscCount + 1'b1; // [RULE_23]
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pscActive <= TBC_PSC_RESET;
    else if (updateEvent)
      pscActive <= prescalerValue; // [RULE_06] [RULE_23]
  end

  // ------------------------------------------------------------------
  // counter and direction
  // ------------------------------------------------------------------
  logic             center;
  logic             down;
  logic             atTop;
  logic             atBottom;
  logic             overflowEv;
  logic             underflowEv;
  logic [CNT_W-1:0] next_reload;
  logic             next_down;
  logic [CNT_W-1:0] next_count;

  assign center = (ctrl.centerAlignSelect != TBC_CMS_EDGE); // [RULE_11]

  // reload shadow: direct when preload off, else only at update
  assign next_reload = ctrl.reloadPreloadEnable ? activeReload : autoReloadValue; // [RULE_22]

  assign atTop       = center ? (counterValue >= activeReload - 1'b1) : (counterValue >= activeReload);
  assign atBottom    = center ? (counterValue <= {{(CNT_W-1){1'b0}}, 1'b1}) : (counterValue == '0);
  assign overflowEv  = counterTick & ~down & atTop; // [RULE_01] [RULE_10]
  assign underflowEv = counterTick & down & atBottom; // [RULE_07] [RULE_10]

  always_comb
  begin
    next_down = down;
    if (!center)
      next_down = ctrl.direction;
    else if (overflowEv)
      next_down = 1'b1; // [RULE_12]
    else if (underflowEv | forceNow)
      next_down = 1'b0; // [RULE_12]
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      down <= 1'b0;
    else
      down <= next_down;
  end

  // reload value the counter sees on this cycle's underflow
  function automatic logic [CNT_W-1:0] next_shadow(input logic upd);
    next_shadow = upd ? autoReloadValue : activeReload; // [RULE_09]
  endfunction : next_shadow

  always_comb
  begin
    next_count = counterValue;
    if (forceNow)
      next_count = (down & !center) ? next_shadow(updateEvent) : '0; // [RULE_03] [RULE_13]
    else if (overflowEv)
      next_count = center ? activeReload : '0; // [RULE_01] [RULE_04] [RULE_10]
    else if (underflowEv)
      next_count = center ? '0 : next_shadow(updateEvent); // [RULE_07] [RULE_08] [RULE_09] [RULE_14]
    else if (counterTick)
      next_count = down ? counterValue - 1'b1 : counterValue + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      counterValue <= TBC_CNT_RESET;
    else
      counterValue <= next_count;
  end

  // ------------------------------------------------------------------
  // repetition counter and update event
  // ------------------------------------------------------------------
  logic [REP_W-1:0] repCount;
  logic             flowEv;
  logic             updFire;
  logic [REP_W-1:0] next_rep;

  assign flowEv  = center ? (overflowEv | underflowEv) : (down ? underflowEv : overflowEv); // [RULE_15]
  // repetition width bounds center mode to 128 periods
  assign updFire = flowEv & (repCount == '0); // [RULE_02] [RULE_15] [RULE_16] [RULE_19]
  assign updateEvent = ~ctrl.updateDisable & (updFire | forceNow); // [RULE_03] [RULE_04]

  always_comb
  begin
    next_rep = repCount;
    if (updateEvent)
      next_rep = repetitionValue; // [RULE_06] [RULE_17]
    else if (flowEv & (repCount != '0))
      next_rep = repCount - 1'b1; // [RULE_15] [RULE_18]
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      repCount <= TBC_REP_RESET;
    else
      repCount <= next_rep;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      activeReload <= TBC_ARR_RESET;
    else if (updateEvent)
      activeReload <= autoReloadValue; // [RULE_06] [RULE_16]
    else
      activeReload <= next_reload; // [RULE_22]
  end

  // ------------------------------------------------------------------
  // update flag and status
  // ------------------------------------------------------------------
  logic flagSet;
  logic next_window;

  assign flagSet = updateEvent & ~(forceNow & ctrl.updateRequestSource); // [RULE_05]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      updateFlag <= 1'b0;
    else if (flagSet)
      updateFlag <= 1'b1; // [RULE_06]
    else if (updateFlagClear)
      updateFlag <= 1'b0;
  end

  // compare flag window per center-align select
  always_comb
  begin
    case (ctrl.centerAlignSelect)
      TBC_CMS_EDGE:     next_window = 1'b1;
      TBC_CMS_DOWNFLAG: next_window = down; // [RULE_11]
      TBC_CMS_UPFLAG:   next_window = ~down; // [RULE_11]
      TBC_CMS_BOTH:     next_window = 1'b1; // [RULE_11]
      default:          next_window = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      stat <= '0;
    else
    begin
      stat.updateEvent       <= updateEvent;
      stat.overflow          <= overflowEv;
      stat.underflow         <= underflowEv;
      stat.countingDown      <= down; // [RULE_12]
      stat.compareFlagWindow <= next_window; // [RULE_11]
    end
  end

endmodule : tbc_time_base

// >>> tb/tbc_time_base_monitor.sv
`timescale 1ns/1ps
module tbc_time_base_monitor
  import tbc_pkg::*;
#(
  parameter int CNT_W = TBC_CNT_W
)(
  // watched ports
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire tbc_pkg::tbc_ctrl_t    ctrl,
  input wire tbc_pkg::tbc_clk_sel_t clkSelect,
  input wire logic                  forceUpdateBit,
  input wire logic [CNT_W-1:0]      prescalerValue,
  input wire tbc_pkg::tbc_stat_t    stat,
  input wire logic                  updateFlag,
  input wire logic [CNT_W-1:0]      counterValue,
  input wire logic [CNT_W-1:0]      activeReload
);
  import tbc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic upMode;
  logic dnMode;
  assign upMode = ctrl.counterEnable && ctrl.centerAlignSelect == TBC_CMS_EDGE && !ctrl.direction;
  assign dnMode = ctrl.counterEnable && ctrl.centerAlignSelect == TBC_CMS_EDGE && ctrl.direction;
  sequence s_settled; $stable(ctrl) && $past(ctrl, 2) == ctrl && $changed(counterValue); endsequence
  sequence s_force; forceUpdateBit && !ctrl.updateDisable; endsequence
  sequence s_start; $rose(ctrl.counterEnable) && upMode && prescalerValue == '0 && counterValue != activeReload
    && clkSelect == TBC_CLK_INTERNAL; endsequence
  property p_upStep; upMode ##0 s_settled |-> counterValue == $past(counterValue) + 1'b1 || counterValue == '0;
  endproperty
  a_upStep: assert property (p_upStep) else $error("up step wrong");
  property p_dnStep; dnMode ##0 s_settled |-> counterValue == $past(counterValue) - 1'b1 || counterValue == activeReload;
  endproperty
  a_dnStep: assert property (p_dnStep) else $error("down step wrong");
  property p_ovf; stat.overflow && $past(upMode) |-> counterValue == '0
    && $past(counterValue) >= $past(activeReload); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow without wrap");
  property p_unf; stat.underflow && $past(dnMode) |-> $past(counterValue) == '0
    && counterValue == activeReload; endproperty
  a_unf: assert property (p_unf) else $error("underflow without reload");
  property p_flag; stat.updateEvent && !ctrl.updateRequestSource |-> updateFlag; endproperty
  a_flag: assert property (p_flag) else $error("update flag not set");
  property p_update_disable; ctrl.updateDisable [*3] |-> !stat.updateEvent; endproperty
  a_update_disable: assert property (p_update_disable) else $error("update while disabled");
  property p_force; s_force |-> ##[1:2] stat.updateEvent; endproperty
  a_force: assert property (p_force) else $error("forced update missing");
  property p_ctrForce; s_force ##0 ctrl.centerAlignSelect != TBC_CMS_EDGE |-> ##[1:2] counterValue == '0; endproperty
  a_ctrForce: assert property (p_ctrForce) else $error("center force no restart");
  property p_start; s_start |-> ##1 $stable(counterValue) ##1 counterValue == $past(counterValue) + 1'b1; endproperty
  a_start: assert property (p_start) else $error("start delay wrong");
  property p_window; !$past(rst) |-> stat.compareFlagWindow == ($past(ctrl.centerAlignSelect) == TBC_CMS_EDGE
    || $past(ctrl.centerAlignSelect) == TBC_CMS_BOTH
    || ($past(ctrl.centerAlignSelect) == TBC_CMS_DOWNFLAG && stat.countingDown)
    || ($past(ctrl.centerAlignSelect) == TBC_CMS_UPFLAG && !stat.countingDown)); endproperty
  a_window: assert property (p_window) else $error("compare window wrong");
endmodule : tbc_time_base_monitor

bind tbc_time_base tbc_time_base_monitor #(.CNT_W(CNT_W)) tbc_time_base_monitor_inst (.sys_clk, .rst, .ctrl,
  .clkSelect, .forceUpdateBit, .prescalerValue, .stat, .updateFlag, .counterValue, .activeReload);

// >>> tb/tbc_time_base_tb_top.sv
`timescale 1ns/1ps
module tbc_time_base_tb_top;
  import tbc_pkg::*;
  logic         sys_clk;
  logic         rst;
  tbc_ctrl_t    ctrl;
  logic [2:0]   slaveModeSelect;
  tbc_clk_sel_t clkSelect;
  logic         forceUpdateBit;
  logic         slaveForceUpdate;
  logic         updateFlagClear;
  logic [15:0]  autoReloadValue;
  logic [15:0]  prescalerValue;
  logic [7:0]   repetitionValue;
  logic [2:0]   ext;
  tbc_stat_t    stat;
  logic         updateFlag;
  logic [15:0]  counterValue;
  logic [15:0]  activeReload;
  int           errCount;
  int           nTests;
  int           n;
  int           k;
  tbc_time_base tbc_time_base_inst (.sys_clk, .rst, .ctrl, .slaveModeSelect, .clkSelect, .forceUpdateBit,
    .slaveForceUpdate, .updateFlagClear, .autoReloadValue, .prescalerValue, .repetitionValue, .pinClock(ext[0]),
    .externalTriggerInput(ext[1]), .internalTriggerInputs(ext[2]), .stat, .updateFlag, .counterValue, .activeReload);
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    nTests++;
    if (act !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: got %0h expected %0h", $time, act, exp);
    end
  endtask : chk
  task automatic pulse(input logic slv);
    @(posedge sys_clk);
    slaveForceUpdate <= slv;
    forceUpdateBit <= !slv;
    @(posedge sys_clk);
    slaveForceUpdate <= 1'b0;
    forceUpdateBit <= 1'b0;
  endtask : pulse
  // load preloads through a forced update, then start
  task automatic cfg(input logic [6:0] c, input logic [15:0] a, input logic [15:0] p, input logic [7:0] r);
    @(posedge sys_clk);
    ctrl <= tbc_ctrl_t'(c & 7'h3F);
    autoReloadValue <= a;
    prescalerValue <= p;
    repetitionValue <= r;
    pulse(1'b0);
    @(posedge sys_clk);
    ctrl <= tbc_ctrl_t'(c);
    repeat (4) @(posedge sys_clk);
  endtask : cfg
  // cycles between two natural update events
  task automatic period(output int p);
    repeat (2)
    begin
      p = 0;
      do
      begin
        @(negedge sys_clk);
        p++;
      end while (stat.updateEvent !== 1'b1 && p < 500);
    end
  endtask : period
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finishTest
  initial
  begin
    #20000;
    errCount++;
    finishTest();
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    errCount = 0;
    nTests = 0;
    {ctrl, slaveModeSelect, forceUpdateBit, slaveForceUpdate, updateFlagClear, prescalerValue, repetitionValue, ext} = '0;
    autoReloadValue = 16'h0005;
    clkSelect = TBC_CLK_INTERNAL;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    cfg(7'h40, 16'h0005, 16'h0000, 8'h00);
    period(n);
    chk(n, 6);
    chk(updateFlag, 1'b1);
    cfg(7'h40, 16'h0005, 16'h0000, 8'h02);
    period(n);
    chk(n, 18);
    cfg(7'h40, 16'h0005, 16'h0001, 8'h00);
    period(n);
    chk(n, 12);
    $display("up mode done");
    @(posedge sys_clk);
    ctrl <= tbc_ctrl_t'(7'h68);
    autoReloadValue <= 16'h0009;
    repeat (3) @(posedge sys_clk);
    n = 0;
    k = 0;
    repeat (60)
    begin
      @(negedge sys_clk);
      n += stat.updateEvent;
      k += (counterValue == '0);
    end
    chk(n, 0);
    chk(k > 5, 1'b1);
    chk(activeReload, 16'h0005);
    $display("update disable done");
    cfg(7'h44, 16'h0005, 16'h0000, 8'h00);
    period(n);
    chk(n, 6);
    @(posedge sys_clk);
    ctrl <= tbc_ctrl_t'(7'h4C);
    autoReloadValue <= 16'h0003;
    period(n);
    chk(n, 4);
    $display("down mode done");
    for (int c = 1; c < 4; c++)
    begin
      cfg(7'h44 | 7'(c), 16'h0004, 16'h0000, 8'h00);
      period(n);
      chk(n, 4);
      n = 0;
      k = 0;
      repeat (8)
      begin
        @(negedge sys_clk);
        n += stat.countingDown;
        k += stat.compareFlagWindow;
      end
      chk(n, 4);
      chk(k, (c == 3) ? 8 : 4);
    end
    $display("center mode done");
    cfg(7'h10, 16'h0005, 16'h0000, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge sys_clk);
      slaveModeSelect <= s ? 3'h6 : TBC_SMS_OFF;
      updateFlagClear <= 1'b1;
      @(posedge sys_clk);
      updateFlagClear <= 1'b0;
      pulse(s[0]);
      n = 0;
      repeat (3)
      begin
        @(negedge sys_clk);
        n += stat.updateEvent;
      end
      chk(n, 1);
      chk(updateFlag, 1'b0);
    end
    slaveModeSelect <= TBC_SMS_OFF;
    $display("forced update done");
    for (int s = 1; s < 4; s++)
    begin
      clkSelect <= tbc_clk_sel_t'(s);
      cfg(7'h40, 16'h0064, 16'h0000, 8'h00);
      repeat (5)
      begin
        ext[s-1] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext[s-1] <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      @(negedge sys_clk);
      chk(counterValue, 16'h0005);
    end
    $display("clock sources done");
    finishTest();
  end
endmodule : tbc_time_base_tb_top
